// >>> inc/rom_pkg.sv
// package: register map, field positions, reset values and source codes for the output mux
package rom_pkg;
  localparam logic [7:0] OFS_OVERRIDE = 8'h09;
  localparam logic [7:0] OFS_SIGDET = 8'h14;
  localparam logic [7:0] OFS_DIVSEL = 8'h18;
  localparam logic [7:0] OFS_OUTSEL = 8'h1E;
  localparam logic [7:0] OFS_RAWCTL = 8'h3F;
  localparam logic [7:0] RST_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_SIGDET = 8'h00;
  localparam logic [7:0] RST_DIVSEL = 8'h00;
  localparam logic [7:0] RST_OUTSEL = 8'hE0;
  localparam logic [7:0] RST_RAWCTL = 8'h00;
  localparam int BIT_MUX_OVR = 5;
  localparam int BIT_QCLK_OVR = 4;
  localparam int BIT_DIV_OVR = 2;
  localparam int BIT_SD_FORCE_ON = 7;
  localparam int BIT_SD_FORCE_OFF = 6;
  localparam int BIT_QCLK_EN = 0;
  localparam int BIT_RAW_MODE = 7;
  localparam int SEL_LSB = 5;
  localparam int DIV_LSB = 4;
  localparam logic [2:0] DIV_MAX_CODE = 3'h4;
  typedef enum logic [2:0] {
    SRC_RAW = 3'h0,
    SRC_RETIMED = 3'h1,
    SRC_ICLK = 3'h2,
    SRC_QCLK = 3'h3,
    SRC_PRBS = 3'h4,
    SRC_TENMHZ = 3'h5,
    SRC_INVALID = 3'h6,
    SRC_MUTE = 3'h7
  } rom_src_t;
endpackage : rom_pkg

// >>> inc/rom_cfg_if.sv
// interface: configuration fields passed from the register file to the output logic
`timescale 1ns/10ps
interface rom_cfg_if;
  import rom_pkg::*;
  logic mux_ovr;
  logic qclk_ovr;
  logic div_ovr;
  logic [2:0] div_code;
  logic sd_force_on;
  logic sd_force_off;
  logic qclk_en;
  logic raw_mode;
  rom_src_t sel;
  modport regs (output mux_ovr, qclk_ovr, div_ovr, div_code, sd_force_on, sd_force_off,
                output qclk_en, raw_mode, sel);
  modport user (input mux_ovr, qclk_ovr, div_ovr, div_code, sd_force_on, sd_force_off,
                input qclk_en, raw_mode, sel);
endinterface : rom_cfg_if

// >>> hdl/rom_regs.sv
// register file: five byte registers behind the management write/read port
`timescale 1ns/10ps
module rom_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rvalid,
  rom_cfg_if.regs cfg
);
  import rom_pkg::*;
  logic [7:0] ovr_reg, ovr_next;
  logic [7:0] sd_reg, sd_next;
  logic [7:0] div_reg, div_next;
  logic [7:0] sel_reg, sel_next;
  logic [7:0] raw_reg, raw_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  // write decode and read mux; unmapped offsets read as zero
  always_comb begin
    ovr_next = ovr_reg;
    sd_next = sd_reg;
    div_next = div_reg;
    sel_next = sel_reg;
    raw_next = raw_reg;
    rdata_next = rdata_reg;
    rvalid_next = rd_en;
    if (wr_en) begin
      case (addr)
        OFS_OVERRIDE: ovr_next = wdata;
        OFS_SIGDET: sd_next = wdata;
        OFS_DIVSEL: div_next = wdata;
        OFS_OUTSEL: sel_next = wdata;
        OFS_RAWCTL: raw_next = wdata;
        default: ;
      endcase
    end
    if (rd_en) begin
      case (addr)
        OFS_OVERRIDE: rdata_next = ovr_reg;
        OFS_SIGDET: rdata_next = sd_reg;
        OFS_DIVSEL: rdata_next = div_reg;
        OFS_OUTSEL: rdata_next = sel_reg;
        OFS_RAWCTL: rdata_next = raw_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // storage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ovr_reg <= RST_OVERRIDE;
      sd_reg <= RST_SIGDET;
      div_reg <= RST_DIVSEL;
      sel_reg <= RST_OUTSEL;
      raw_reg <= RST_RAWCTL;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      ovr_reg <= ovr_next;
      sd_reg <= sd_next;
      div_reg <= div_next;
      sel_reg <= sel_next;
      raw_reg <= raw_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign rdata = rdata_reg;
  assign rvalid = rvalid_reg;
  assign cfg.mux_ovr = ovr_reg[BIT_MUX_OVR];
  assign cfg.qclk_ovr = ovr_reg[BIT_QCLK_OVR];
  assign cfg.div_ovr = ovr_reg[BIT_DIV_OVR];
  assign cfg.div_code = div_reg[DIV_LSB +: 3];
  assign cfg.sd_force_on = sd_reg[BIT_SD_FORCE_ON];
  assign cfg.sd_force_off = sd_reg[BIT_SD_FORCE_OFF];
  assign cfg.qclk_en = sel_reg[BIT_QCLK_EN];
  assign cfg.raw_mode = raw_reg[BIT_RAW_MODE];
  assign cfg.sel = rom_src_t'(sel_reg[SEL_LSB +: 3]);
endmodule : rom_regs

// >>> hdl/rom_divsel.sv
// divider selection: automatic ratio or register override, as a one-hot-free log2 code
`timescale 1ns/10ps
module rom_divsel (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] auto_code,
  rom_cfg_if.user cfg,
  output logic [2:0] div_log2
);
  import rom_pkg::*;
  logic [2:0] code_reg, code_next;

  // override follows the field; out-of-range codes keep the last good ratio
  always_comb begin
    code_next = code_reg;
    if (cfg.div_ovr) begin
      if (cfg.div_code <= DIV_MAX_CODE) begin
        code_next = cfg.div_code;
      end
    end else if (auto_code <= DIV_MAX_CODE) begin
      code_next = auto_code;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      code_reg <= 3'h0;
    end else begin
      code_reg <= code_next;
    end
  end

  assign div_log2 = code_reg;
endmodule : rom_divsel

// >>> hdl/rom_top.sv
// top: per-channel output source selection, signal detect force and divider override
//
// Contract
// - default: mute unless locked, then retimed
// - select codes 7 mute down to 0 raw
// - quadrature clock needs both enable bits
// - raw output under override needs raw bit; unlocked select picks raw freely
// - select acts when present but unlocked
// - override: select field picks output, illegal picks mute
// - raw bit stops fast coarse re-search
// - no signal, no force: channel powered down
// - force on: detect active without input
// - both bits clear: own detection rules
// - PRBS free-runs unless locked, then synced
// - 10 MHz clock always selectable under override
// - locked: clocks and PRBS track input
// - automatic divider ratio 1 to 16
// - divider override follows field 0 to 4
// - code 0 divide-by-1, up to 16
`timescale 1ns/10ps
module rom_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic sig_present,
  input wire logic cdr_locked,
  input wire logic [2:0] auto_div_code,
  output logic [2:0] out_src,
  output logic out_enable,
  output logic chan_powered,
  output logic prbs_sync_to_input,
  output logic coarse_research_en,
  output logic [4:0] div_ratio
);
  import rom_pkg::*;

  rom_cfg_if cfg ();
  logic [7:0] rdata_w;
  logic rvalid_w;
  logic [2:0] div_log2;
  logic sig_det;
  rom_src_t src_next;
  logic [2:0] src_reg;
  logic en_reg, en_next;
  logic pwr_reg, pwr_next;
  logic sync_reg, sync_next;
  logic research_reg, research_next;
  logic [4:0] ratio_reg, ratio_next;
  logic [7:0] rdata_reg;
  logic rvalid_reg;

  rom_regs u_regs (
    .clk(clk),
    .resetn(resetn),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .addr(addr),
    .wdata(wdata),
    .rdata(rdata_w),
    .rvalid(rvalid_w),
    .cfg(cfg)
  );

  rom_divsel u_div (
    .clk(clk),
    .resetn(resetn),
    .auto_code(auto_div_code),
    .cfg(cfg),
    .div_log2(div_log2)
  );

  // filter a requested source against its enable conditions; bad picks fall to mute
  function automatic rom_src_t legal_src(input rom_src_t req, input logic mux_ovr,
                                         input logic qclk_ok, input logic raw_ok);
    case (req)
      SRC_QCLK: legal_src = qclk_ok ? SRC_QCLK : SRC_MUTE;
      SRC_RAW: legal_src = (raw_ok || !mux_ovr) ? SRC_RAW : SRC_MUTE;
      SRC_TENMHZ: legal_src = SRC_TENMHZ;
      SRC_INVALID: legal_src = SRC_MUTE;
      default: legal_src = req;
    endcase
  endfunction : legal_src

  // signal detect: forced on only with pattern 10, otherwise the detector decides
  always_comb begin
    if (cfg.sd_force_on && !cfg.sd_force_off) begin
      sig_det = 1'b1;
    end else begin
      sig_det = sig_present;
    end
  end

  // output mux priority: override, then no-detect mute, then lock state, then unlocked select
  always_comb begin
    src_next = SRC_MUTE;
    pwr_next = sig_det;
    if (cfg.mux_ovr) begin
      src_next = legal_src(cfg.sel, 1'b1, cfg.qclk_ovr && cfg.qclk_en,
                           cfg.raw_mode);
    end else if (!sig_det) begin
      src_next = SRC_MUTE;
    end else if (cdr_locked) begin
      src_next = SRC_RETIMED;
    end else begin
      src_next = legal_src(cfg.sel, 1'b0, cfg.qclk_ovr && cfg.qclk_en, 1'b1);
    end
    // driver is unpowered without detect, so any pick other than mute is moot
    en_next = pwr_next && (src_next != SRC_MUTE);
    // prbs and vco clocks follow the input only while locked to it
    sync_next = sig_det && cdr_locked;
    // raw mode holds the coarse tuning still so the output is not dropped
    research_next = !cfg.raw_mode;
    ratio_next = 5'(5'h01 << div_log2);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_reg <= SRC_MUTE;
      en_reg <= 1'b0;
      pwr_reg <= 1'b0;
      sync_reg <= 1'b0;
      research_reg <= 1'b1;
      ratio_reg <= 5'h01;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      src_reg <= src_next;
      en_reg <= en_next;
      pwr_reg <= pwr_next;
      sync_reg <= sync_next;
      research_reg <= research_next;
      ratio_reg <= ratio_next;
      rdata_reg <= rdata_w;
      rvalid_reg <= rvalid_w;
    end
  end

  assign out_src = src_reg;
  assign out_enable = en_reg;
  assign chan_powered = pwr_reg;
  assign prbs_sync_to_input = sync_reg;
  assign coarse_research_en = research_reg;
  assign div_ratio = ratio_reg;
  assign rdata = rdata_reg;
  assign rvalid = rvalid_reg;
endmodule : rom_top

// >>> bench/rom_top_asserts.sv
// checker: port-level assertions for the retimer output mux
`timescale 1ns/10ps
module rom_top_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic sig_present,
  input wire logic cdr_locked,
  input wire logic [2:0] out_src,
  input wire logic out_enable,
  input wire logic chan_powered,
  input wire logic prbs_sync_to_input,
  input wire logic coarse_research_en,
  input wire logic [4:0] div_ratio
);
  import rom_pkg::*;
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  // shadow of host writes: 0 mux override, 1 force on, 2 raw mode
  always_comb begin
    sh_next = sh_reg;
    if (wr_en && addr == OFS_OVERRIDE) sh_next[0] = wdata[BIT_MUX_OVR];
    if (wr_en && addr == OFS_SIGDET) sh_next[1] = (wdata[7:6] == 2'h2);
    if (wr_en && addr == OFS_RAWCTL) sh_next[2] = wdata[BIT_RAW_MODE];
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) sh_reg <= 3'h0;
    else sh_reg <= sh_next;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // four steady cycles outlast the write-to-output latency
  sequence s_dark;
    (!sig_present && !sh_reg[1])[*4];
  endsequence
  sequence s_lock;
    (!sh_reg[0] && sig_present && cdr_locked)[*4];
  endsequence
  dark_chan_off_a:
  assert property (s_dark |=> !chan_powered && !out_enable) else $error("powered, no signal");
  lock_retimed_a:
  assert property (s_lock |=> out_src == SRC_RETIMED && out_enable) else $error("not retimed");
  force_on_a:
  assert property ((sh_reg[1])[*4] |=> chan_powered) else $error("force ignored");
  raw_research_a:
  assert property (($stable(sh_reg[2]))[*4] |=> coarse_research_en == !$past(sh_reg[2]))
    else $error("re-search wrong");
  no_invalid_a:
  assert property (out_src != SRC_INVALID) else $error("invalid source out");
  enable_cause_a:
  assert property (out_enable |-> chan_powered && out_src != SRC_MUTE) else $error("bad enable");
  div_onehot_a:
  assert property ($onehot(div_ratio)) else $error("bad ratio");
  prbs_sync_a:
  assert property ((sig_present && cdr_locked)[*3] |=> prbs_sync_to_input && chan_powered)
    else $error("prbs not synced");
endmodule : rom_top_asserts

// >>> bench/rom_far_model.sv
// far-side model: line signal source feeding detect, lock and rate code
`timescale 1ns/10ps
module rom_far_model (
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire logic [2:0] rate,
  output logic sig_present = 1'h0,
  output logic cdr_locked = 1'h0,
  output logic [2:0] auto_div_code = 3'h0
);
  // mode 0 no signal, 1 unlocked, 2 locked; lock never without signal
  always @(negedge clk) begin
    sig_present <= (mode != 2'h0);
    cdr_locked <= (mode == 2'h2);
    auto_div_code <= rate;
  end
endmodule : rom_far_model

// >>> bench/tb_top.sv
// testbench: mux table, divider override, resets and register reads
`timescale 1ns/10ps
module tb_top;
  import rom_pkg::*;
  typedef struct packed {
    logic [7:0] ovr;
    logic [7:0] sel;
    logic [7:0] raw;
    logic [7:0] sd;
    logic [1:0] mode;
    logic [2:0] src;
  } rom_row_t;
  // writes to 0x09, 0x1E, 0x3F, 0x14, far-side mode, expected source
  localparam rom_row_t ROWS [12] = '{
    '{8'h00, 8'hE0, 8'h00, 8'h00, 2'h0, 3'h7},
    '{8'h00, 8'hE0, 8'h00, 8'h00, 2'h1, 3'h7},
    '{8'h00, 8'h00, 8'h00, 8'h00, 2'h1, 3'h0},
    '{8'h00, 8'h80, 8'h00, 8'h00, 2'h2, 3'h1},
    '{8'h20, 8'hA0, 8'h00, 8'h80, 2'h0, 3'h5},
    '{8'h20, 8'h80, 8'h00, 8'h00, 2'h2, 3'h4},
    '{8'h20, 8'h60, 8'h00, 8'h00, 2'h2, 3'h7},
    '{8'h30, 8'h61, 8'h00, 8'h00, 2'h2, 3'h3},
    '{8'h20, 8'h00, 8'h00, 8'h00, 2'h1, 3'h7},
    '{8'h20, 8'h00, 8'h80, 8'h00, 2'h1, 3'h0},
    '{8'h20, 8'hC0, 8'h00, 8'h00, 2'h2, 3'h7},
    '{8'h20, 8'h40, 8'h00, 8'h00, 2'h1, 3'h2}
  };
  logic clk, resetn, wr_en, rd_en, rvalid, sig_present, cdr_locked, pw;
  logic out_enable, chan_powered, prbs_sync_to_input, coarse_research_en;
  logic [7:0] addr, wdata, rdata, d;
  logic [2:0] auto_div_code, rate, out_src;
  logic [4:0] div_ratio;
  logic [1:0] mode;
  int fail_count, samples_checked, c;
  rom_top dut (.clk, .resetn, .wr_en, .rd_en, .addr, .wdata, .rdata, .rvalid,
    .sig_present, .cdr_locked, .auto_div_code, .out_src, .out_enable, .chan_powered,
    .prbs_sync_to_input, .coarse_research_en, .div_ratio);
  rom_far_model far (.clk, .mode, .rate, .sig_present, .cdr_locked, .auto_div_code);
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test;
    $display("compared %0d mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one write per strobe cycle; strobe drops before the next request
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    wr_en = 1'h1;
    addr = a;
    wdata = v;
    @(negedge clk);
    wr_en = 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    int n;
    @(negedge clk);
    rd_en = 1'h1;
    addr = a;
    @(negedge clk);
    rd_en = 1'h0;
    for (n = 0; n < 4 && rvalid !== 1'h1; n++) begin
      @(posedge clk);
      #1;
    end
    chk({7'h0, rvalid}, 8'h01);
    v = rdata;
    if (rvalid !== 1'h1) stop_test();
  endtask : rd
  initial begin
    resetn = 1'h0;
    wr_en = 1'h0;
    rd_en = 1'h0;
    addr = 8'h00;
    wdata = 8'h00;
    mode = 2'h0;
    rate = 3'h0;
    repeat (2) @(negedge clk);
    chk({5'h0, out_src}, 8'h07);
    resetn = 1'h1;
    rd(OFS_OUTSEL, d);
    chk(d, RST_OUTSEL);
    rd(8'h20, d);
    chk(d, 8'h00);
    foreach (ROWS[i]) begin
      wr(OFS_OVERRIDE, ROWS[i].ovr);
      wr(OFS_OUTSEL, ROWS[i].sel);
      wr(OFS_RAWCTL, ROWS[i].raw);
      wr(OFS_SIGDET, ROWS[i].sd);
      mode = ROWS[i].mode;
      pw = ROWS[i].mode != 2'h0 || ROWS[i].sd[7:6] == 2'h2;
      repeat (6) @(negedge clk);
      chk({5'h0, out_src}, {5'h0, ROWS[i].src});
      chk({7'h0, out_enable}, {7'h0, pw && ROWS[i].src != 3'h7});
      chk({7'h0, coarse_research_en}, {7'h0, !ROWS[i].raw[7]});
      chk({7'h0, prbs_sync_to_input}, {7'h0, ROWS[i].mode == 2'h2});
    end
    // codes 0..4 map to ratios; 5 is out of range and must hold 16
    wr(OFS_OVERRIDE, 8'h04);
    for (c = 0; c < 6; c++) begin
      wr(OFS_DIVSEL, {1'h0, c[2:0], 4'h0});
      repeat (6) @(negedge clk);
      chk({3'h0, div_ratio}, 8'h01 << (c > 4 ? 4 : c));
    end
    rate = 3'h3;
    wr(OFS_OVERRIDE, 8'h00);
    repeat (6) @(negedge clk);
    chk({3'h0, div_ratio}, 8'h08);
    mode = 2'h0;
    wr(OFS_SIGDET, 8'hC0);
    repeat (6) @(negedge clk);
    chk({7'h0, chan_powered}, 8'h00);
    // force on, then both bits cleared hands detect back to the idle line
    wr(OFS_SIGDET, 8'h80);
    repeat (6) @(negedge clk);
    chk({7'h0, chan_powered}, 8'h01);
    wr(OFS_SIGDET, 8'h00);
    repeat (6) @(negedge clk);
    chk({7'h0, chan_powered}, 8'h00);
    resetn = 1'h0;
    @(negedge clk);
    chk({3'h0, div_ratio}, 8'h01);
    resetn = 1'h1;
    // select field must be back at mute after a mid-run reset
    rd(OFS_OUTSEL, d);
    chk(d, RST_OUTSEL);
    stop_test();
  end
endmodule : tb_top
bind rom_top rom_top_asserts chk_i (.clk, .resetn, .wr_en, .addr, .wdata, .sig_present,
  .cdr_locked, .out_src, .out_enable, .chan_powered, .prbs_sync_to_input,
  .coarse_research_en, .div_ratio);
